// ### common/ppm_regs.svh
// Offsets, field positions and fixed values of the port power-management registers.
`ifndef PPM_REGS_SVH
`define PPM_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PPM_CAP_OFFSET       8'h52
`define PPM_CSR_OFFSET       8'h54

// ****************************************************************
// Capability fields
// ****************************************************************
`define PPM_CAP_MASK_D3COLD  15
`define PPM_CAP_MASK_D3HOT   14
`define PPM_CAP_MASK_D2      13
`define PPM_CAP_MASK_D1      12
`define PPM_CAP_MASK_D0      11
`define PPM_CAP_DEEP_SLEEP   10
`define PPM_CAP_LIGHT_SLEEP  9
`define PPM_CAP_AUX_HI       8
`define PPM_CAP_AUX_LO       6
`define PPM_AUX_CODE_ON      3'h1
`define PPM_AUX_CODE_OFF     3'h0
`define PPM_CAP_SPEC_HI      2
`define PPM_CAP_SPEC_LO      0
`define PPM_SPEC_REVISION    3'h3

// ****************************************************************
// Control/status fields
// ****************************************************************
`define PPM_CSR_PENDING      15
`define PPM_CSR_ENABLE       8
`define PPM_CSR_KEEPS_STATE  3
`define PPM_CSR_STATE_HI     1
`define PPM_CSR_STATE_LO     0
`define PPM_CSR_RESET        16'h0008

`endif

// ### common/ppm_pkg.sv
// Types shared by the port power-management register files.
package ppm_pkg;

	typedef enum logic [1:0] {
		PPM_D0    = 2'b00,
		PPM_D1    = 2'b01,
		PPM_D2    = 2'b10,
		PPM_D3HOT = 2'b11
	} ppm_pstate_t;

	typedef struct packed {
		logic flag;
	} ppm_flag_state_t;

	typedef struct packed {
		logic        wake_enable;
		ppm_pstate_t pstate;
		logic [15:0] rdata;
		logic        rvalid;
	} ppm_state_t;

endpackage

// ### core/ppm_flag.sv
// Sticky event flag where a set wins over a software clear in the same cycle, but global reset wins over a set.
`timescale 1ns/10ps
`include "ppm_regs.svh"
module ppm_flag
	import ppm_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic global_reset,
	input  wire logic set,
	input  wire logic clear,
	output logic      flag
);

	ppm_flag_state_t st;
	ppm_flag_state_t next_st;

	// The event is not lost when software clears in the same cycle.
	always_comb begin
		next_st = st;
		if (clear) begin
			next_st.flag = 1'b0;
		end
		if (set) begin
			next_st.flag = 1'b1;
		end
		if (global_reset) begin
			next_st.flag = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign flag = st.flag;

endmodule // ppm_flag

// ### core/ppm_regs_core.sv
// Power-management capability and control/status registers of one downstream port.
`timescale 1ns/10ps
`include "ppm_regs.svh"
module ppm_regs_core
	import ppm_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	input  wire logic              global_reset,
	input  wire logic              port_reset,
	input  wire logic              aux_supply_present,
	input  wire logic              light_sleep_supported,
	input  wire logic              hotplug_wake_event,
	input  wire logic [ADDR_W-1:0] cfg_addr,
	input  wire logic              cfg_rd,
	input  wire logic              cfg_wr,
	input  wire logic [1:0]        cfg_be,
	input  wire logic [15:0]       cfg_wdata,
	output logic [15:0]            cfg_rdata,
	output logic                   cfg_rvalid,
	output logic [1:0]             power_state,
	output logic                   wake_event_pending,
	output logic                   wake_event_enable,
	output logic                   wake_signal_req
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (ADDR_W < 7) begin : g_bad_addr
		$error("ADDR_W too narrow for the register offsets.");
	end

	// ****************************************************************
	// Decode
	// ****************************************************************
	localparam logic [ADDR_W-1:0] CAP_ADDR = ADDR_W'(`PPM_CAP_OFFSET);
	localparam logic [ADDR_W-1:0] CSR_ADDR = ADDR_W'(`PPM_CSR_OFFSET);

	ppm_state_t  st;
	ppm_state_t  next_st;
	logic        csr_wr_hi;
	logic        csr_wr_lo;
	logic        pend_clear;
	logic        pend_flag;
	logic [15:0] cap_word;
	logic [15:0] csr_word;

	assign csr_wr_hi  = cfg_wr && (cfg_addr == CSR_ADDR) && cfg_be[1];
	assign csr_wr_lo  = cfg_wr && (cfg_addr == CSR_ADDR) && cfg_be[0];
	assign pend_clear = csr_wr_hi && cfg_wdata[`PPM_CSR_PENDING];

	// ****************************************************************
	// Pending flag
	// ****************************************************************
	ppm_flag u_pending (
		.sys_clk      (sys_clk),
		.sys_rst      (sys_rst),
		.global_reset (global_reset),
		.set          (hotplug_wake_event),
		.clear        (pend_clear),
		.flag         (pend_flag)
	);

	// ****************************************************************
	// Read words
	// ****************************************************************
	always_comb begin
		cap_word = '0;
		cap_word[`PPM_CAP_MASK_D3COLD] = aux_supply_present;
		cap_word[`PPM_CAP_MASK_D3HOT]  = 1'b1;
		cap_word[`PPM_CAP_MASK_D2]     = 1'b1;
		cap_word[`PPM_CAP_MASK_D1]     = light_sleep_supported;
		cap_word[`PPM_CAP_MASK_D0]     = 1'b1;
		cap_word[`PPM_CAP_DEEP_SLEEP]  = 1'b1;
		cap_word[`PPM_CAP_LIGHT_SLEEP] = light_sleep_supported;
		cap_word[`PPM_CAP_AUX_HI:`PPM_CAP_AUX_LO] =
			aux_supply_present ? `PPM_AUX_CODE_ON : `PPM_AUX_CODE_OFF;
		cap_word[`PPM_CAP_SPEC_HI:`PPM_CAP_SPEC_LO] = `PPM_SPEC_REVISION;
	end

	// The PPM_CSR_RESET fill zeroes the unused data fields and reserved bits and sets the keeps-state bit 3.
	always_comb begin
		csr_word = `PPM_CSR_RESET;
		csr_word[`PPM_CSR_PENDING] = pend_flag;
		csr_word[`PPM_CSR_ENABLE]  = st.wake_enable;
		csr_word[`PPM_CSR_STATE_HI:`PPM_CSR_STATE_LO] = st.pstate;
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_st        = st;
		next_st.rvalid = cfg_rd;
		if (cfg_rd) begin
			case (cfg_addr)
				CAP_ADDR: begin
					next_st.rdata = cap_word;
				end
				CSR_ADDR: begin
					next_st.rdata = csr_word;
				end
				default: begin
					next_st.rdata = '0;
				end
			endcase
		end
		if (csr_wr_hi) begin
			next_st.wake_enable = cfg_wdata[`PPM_CSR_ENABLE];
		end
		// Leaving D3hot only changes the field; no port state is reset here.
		if (csr_wr_lo) begin
			next_st.pstate = ppm_pstate_t'(cfg_wdata[`PPM_CSR_STATE_HI:`PPM_CSR_STATE_LO]);
		end
		// A port reset returns the power state but leaves the sticky bits alone.
		if (port_reset) begin
			next_st.pstate = PPM_D0;
		end
		if (global_reset) begin
			next_st.wake_enable = 1'b0;
			next_st.pstate      = PPM_D0;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '{wake_enable: 1'b0, pstate: PPM_D0, rdata: 16'h0000, rvalid: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign cfg_rdata          = st.rdata;
	assign cfg_rvalid         = st.rvalid;
	assign power_state        = st.pstate;
	assign wake_event_pending = pend_flag;
	assign wake_event_enable  = st.wake_enable;
	// Only a request toward the upstream message logic; this port never drives a wake pin.
	assign wake_signal_req    = pend_flag && st.wake_enable;

endmodule // ppm_regs_core

// ### test/ppm_regs_monitor.sv
// Checker of the port power-management register ports.
`timescale 1ns/10ps
module ppm_regs_monitor #(
	parameter int ADDR_W = 8
) (
	input wire logic              sys_clk,
	input wire logic              sys_rst,
	input wire logic              global_reset,
	input wire logic              port_reset,
	input wire logic              aux_supply_present,
	input wire logic              light_sleep_supported,
	input wire logic              hotplug_wake_event,
	input wire logic [ADDR_W-1:0] cfg_addr,
	input wire logic              cfg_rd,
	input wire logic              cfg_wr,
	input wire logic [1:0]        cfg_be,
	input wire logic [15:0]       cfg_wdata,
	input wire logic [15:0]       cfg_rdata,
	input wire logic [1:0]        power_state,
	input wire logic              wake_event_pending,
	input wire logic              wake_event_enable
);
	// Straps are sampled at the read edge, so the word is compared against their past values.
	wire cap_rd = cfg_rd && cfg_addr == 8'h52;
	wire csr_rd = cfg_rd && cfg_addr == 8'h54;
	wire csr_wr = cfg_wr && cfg_addr == 8'h54;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	a_cap_word: assert property (cap_rd |=> cfg_rdata == {$past(aux_supply_present), 2'b11,
		$past(light_sleep_supported), 2'b11, $past(light_sleep_supported), 2'b00,
		$past(aux_supply_present), 6'h03}) else $error("capability word wrong");
	a_csr_word: assert property (csr_rd |=> {cfg_rdata[14:9], cfg_rdata[7:2]} == 12'h002 &&
		cfg_rdata[15] == $past(wake_event_pending) && cfg_rdata[8] == $past(wake_event_enable)
		&& cfg_rdata[1:0] == $past(power_state)) else $error("control word wrong");
	a_event_sets: assert property (hotplug_wake_event && !global_reset |=> wake_event_pending)
		else $error("event did not set pending");
	a_global_clears: assert property (global_reset |=> !wake_event_pending && !wake_event_enable)
		else $error("global reset left flags");
	a_pending_holds: assert property (wake_event_pending && !global_reset && !cfg_wr |=>
		wake_event_pending) else $error("pending dropped");
	a_one_clears: assert property (csr_wr && cfg_be[1] && cfg_wdata[15] && !hotplug_wake_event
		&& !global_reset |=> !wake_event_pending) else $error("write one did not clear");
	a_enable_write: assert property (csr_wr && cfg_be[1] && !global_reset |=>
		wake_event_enable == $past(cfg_wdata[8])) else $error("enable not written");
	a_state_write: assert property (csr_wr && cfg_be[0] && !global_reset && !port_reset |=>
		power_state == $past(cfg_wdata[1:0])) else $error("state not written");
endmodule // ppm_regs_monitor

bind ppm_regs_core ppm_regs_monitor #(.ADDR_W(ADDR_W)) ppm_regs_monitor_inst (.*);

// ### test/ppm_regs_core_bench.sv
// Self-checking bench of the port power-management registers.
`timescale 1ns/10ps
module ppm_regs_core_bench;
	logic        sys_clk = 0, sys_rst = 1, glob_rst = 0, prst = 0, aux = 0, lss = 0, hp = 0;
	logic        rd = 0, wr = 0, rv, pend, en, req;
	logic [1:0]  be = 0, pst;
	logic [7:0]  addr = 0;
	logic [15:0] wd = 0, rdat, got;
	int          fail_count = 0, checks = 0, cyc = 0;
	ppm_regs_core ppm_regs_core_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .global_reset(glob_rst),
		.port_reset(prst), .aux_supply_present(aux), .light_sleep_supported(lss),
		.hotplug_wake_event(hp), .cfg_addr(addr), .cfg_rd(rd), .cfg_wr(wr), .cfg_be(be),
		.cfg_wdata(wd), .cfg_rdata(rdat), .cfg_rvalid(rv), .power_state(pst),
		.wake_event_pending(pend), .wake_event_enable(en), .wake_signal_req(req));
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// A hang is cut short at 2000 cycles, well beyond the roughly 60 cycles the run needs.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			end_sim();
		end
	end
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 chk("rvalid", {15'h0000, rv}, 16'h0001);
		chk("read", rdat, e);
	endtask
	task automatic wrw(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		be <= b;
		wd <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic t_cap;
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			aux <= i[0];
			lss <= i[1];
			rc(8'h52, {i[0], 2'b11, i[1], 2'b11, i[1], 2'b00, i[0], 6'h03});
		end
		wrw(8'h52, 2'b11, 16'h0000);
		rc(8'h52, 16'hfe43);
		rc(8'h50, 16'h0000);
	endtask
	task automatic t_state;
		for (int i = 3; i >= 0; i--) begin
			wrw(8'h54, 2'b01, 16'hfffc | 16'(i));
			rc(8'h54, 16'h0008 | 16'(i));
		end
		wrw(8'h54, 2'b01, 16'h0002);
		@(posedge sys_clk);
		prst <= 1'b1;
		@(posedge sys_clk);
		prst <= 1'b0;
		#1 chk("state", {14'h0000, pst}, 16'h0000);
		chk("rvalid_idle", {15'h0000, rv}, 16'h0000);
	endtask
	task automatic t_wake;
		@(posedge sys_clk);
		hp <= 1'b1;
		@(posedge sys_clk);
		hp <= 1'b0;
		rc(8'h54, 16'h8008);
		chk("wake_req_off", {15'h0000, req}, 16'h0000);
		wrw(8'h54, 2'b10, 16'h0100);
		#1 chk("wake_req", {15'h0000, req}, 16'h0001);
		wrw(8'h54, 2'b11, 16'hffff);
		rc(8'h54, 16'h010b);
		wrw(8'h54, 2'b01, 16'h0000);
		rc(8'h54, 16'h0108);
		@(posedge sys_clk);
		hp <= 1'b1;
		glob_rst <= 1'b1;
		@(posedge sys_clk);
		hp <= 1'b0;
		glob_rst <= 1'b0;
		rc(8'h54, 16'h0008);
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rc(8'h54, 16'h0008);
		t_cap();
		t_state();
		t_wake();
		end_sim();
	end
endmodule // ppm_regs_core_bench
